/* logic/cwd_sink.sv */
// control wire discovery sink: wake qualification, pulse counting, connect
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - after valid wake, sink arms for the first discovery rising edge.
// - partial or mistimed wake leaves the sink unarmed.
// - pulse counter is zero before discovery begins.
// - high widths in the window count, outside the reject limits fail.
// - low widths are qualified with the same window.
// - any invalid width clears the pulse counter.
// - a qualified high followed by a low adds one pulse.
// - after enough pulses, connect pull-down within delay of next rise.
// - a qualified rise after reaching the required count means connected to a compliant source.
// - connected sink terminates the media pair two cycles after connect, whatever its delay.
// - wire low past the disconnect interval drops back to the discovery pull-down.
module cwd_sink #(
    parameter int unsigned PULSE_MIN     = cwd_pkg::PULSE_MIN_CYC,
    parameter int unsigned PULSE_MAX     = cwd_pkg::PULSE_MAX_CYC,
    parameter int unsigned WAKE_ONE_MIN  = cwd_pkg::WAKE_ONE_MIN_CYC,
    parameter int unsigned WAKE_ONE_MAX  = cwd_pkg::WAKE_ONE_MAX_CYC,
    parameter int unsigned WAKE_TWO_MIN  = cwd_pkg::WAKE_TWO_MIN_CYC,
    parameter int unsigned WAKE_TWO_MAX  = cwd_pkg::WAKE_TWO_MAX_CYC,
    parameter int unsigned WAKE_TO_DISC  = cwd_pkg::WAKE_TO_DISC_CYC,
    parameter int unsigned CONNECT_DELAY = cwd_pkg::CONNECT_DELAY_CYC,
    parameter int unsigned TERM_ENABLE   = cwd_pkg::TERM_ENABLE_CYC,
    parameter int unsigned DISCONNECT    = cwd_pkg::DISCONNECT_CYC,
    parameter int unsigned SINK_PULSES   = cwd_pkg::SINK_PULSES
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  nrst_in,
    // device control
    input  wire logic                  enable_in,
    input  wire logic                  standby_in,
    // control wire, sampled level from the pad
    input  wire logic                  control_wire_in,
    // pad controls
    output cwd_pkg::cwd_pulldown_t     pulldown_out,
    output logic                       media_pair_pos_term_out,
    output logic                       media_pair_neg_term_out,
    // status
    output cwd_pkg::cwd_status_t       status_out
);

    localparam int unsigned W = cwd_pkg::WIDTH_BITS;
    localparam logic [W-1:0] WMAX = '1;

    // every count but the wake-one window and the connect delay must fit the width counters, the doubled wake low included
    if (PULSE_MAX >= 2**W || WAKE_TWO_MAX * 2 >= 2**W || DISCONNECT >= 2**W ||
        WAKE_TO_DISC >= 2**W || TERM_ENABLE >= 2**W) begin : g_width_check
        $error("cwd_sink: timing count exceeds the width counter");
    end
    if (PULSE_MIN > PULSE_MAX || WAKE_ONE_MIN > WAKE_ONE_MAX ||
        WAKE_TWO_MIN > WAKE_TWO_MAX) begin : g_window_check
        $error("cwd_sink: accept window is inverted");
    end
    // the pulse counter is four bits wide and must reach the required count
    if (SINK_PULSES == 0 || SINK_PULSES > 15) begin : g_count_check
        $error("cwd_sink: required pulse count out of range");
    end
    // termination follows connect by two cycles; both delays are checked to be at least one
    if (CONNECT_DELAY == 0 || TERM_ENABLE == 0) begin : g_delay_check
        $error("cwd_sink: connect or termination delay too short");
    end

    // ========================================================================
    // synchroniser
    // ========================================================================
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       lvl_q;
    logic       lvl_d;

    // three stages, change taken when last two agree
    always_comb begin
        sync_d = {sync_q[1:0], control_wire_in};
        lvl_d  = (sync_q[2] == sync_q[1]) ? sync_q[2] : lvl_q;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_q <= 3'h0;
            lvl_q  <= 1'b0;
        end else begin
            sync_q <= sync_d;
            lvl_q  <= lvl_d;
        end
    end

    // edges come from the qualified level, one cycle ahead of lvl_q
    wire logic rise = lvl_d & ~lvl_q;
    wire logic fall = ~lvl_d & lvl_q;
    wire logic edge_seen = rise | fall;

    // ========================================================================
    // width measurement
    // ========================================================================
    function automatic logic in_win(input logic [W-1:0] w, input int unsigned lo,
                                    input int unsigned hi);
        in_win = (w >= lo[W-1:0]) && (w <= hi[W-1:0]);
    endfunction : in_win

    typedef enum {
        ST_IDLE,
        ST_WAKE,
        ST_ARMED,
        ST_DISC,
        ST_CONNECT,
        ST_CONNECTED
    } cwd_state_t;

    cwd_state_t state_q;
    cwd_state_t state_d;
    logic [W-1:0] width_q;
    logic [W-1:0] width_d;
    logic [W-1:0] timer_q;
    logic [W-1:0] timer_d;
    logic [2:0]   wake_q;
    logic [2:0]   wake_d;
    logic [3:0]   count_q;
    logic [3:0]   count_d;
    logic         hi_ok_q;
    logic         hi_ok_d;
    logic         term_q;
    logic         term_d;

    // expected phase widths for the seven checked wake intervals, starting high
    function automatic logic wake_ok(input logic [2:0] idx, input logic [W-1:0] w);
        // idx3 is one wake-two low plus the extra low, seen as a single low
        unique case (idx)
            3'h1:         wake_ok = in_win(w, WAKE_TWO_MIN, WAKE_TWO_MAX);
            3'h3:         wake_ok = in_win(w, 2 * WAKE_TWO_MIN, 2 * WAKE_TWO_MAX);
            default:      wake_ok = in_win(w, WAKE_ONE_MIN, WAKE_ONE_MAX);
        endcase
    endfunction : wake_ok

    always_comb begin
        state_d = state_q;
        // saturating, so a parked wire never wraps back to a short width
        // width counter restarts on every edge
        width_d = edge_seen ? '0 : ((width_q == WMAX) ? width_q : width_q + 1'b1);
        timer_d = (timer_q == WMAX) ? timer_q : timer_q + 1'b1;
        wake_d  = wake_q;
        count_d = count_q;
        hi_ok_d = hi_ok_q;
        term_d  = term_q;
        unique case (state_q)
            ST_IDLE: begin
                count_d = 4'h0;
                wake_d  = 3'h0;
                if (enable_in && rise) begin
                    state_d = standby_in ? ST_WAKE : ST_DISC;
                    hi_ok_d = 1'b0;
                end
            end
            ST_WAKE: begin
                // any mistimed phase drops back to idle
                if (edge_seen) begin
                    if (!wake_ok(wake_q, width_q)) begin
                        state_d = ST_IDLE;
                    end else if (wake_q == 3'h6) begin
                        // full sequence arms for the first discovery edge
                        state_d = ST_ARMED;
                        timer_d = '0;
                    end else begin
                        wake_d = wake_q + 3'h1;
                    end
                end else if (width_q > WAKE_TWO_MAX[W-1:0] * 2) begin
                    state_d = ST_IDLE;
                end
            end
            ST_ARMED: begin
                count_d = 4'h0;
                if (rise) begin
                    state_d = ST_DISC;
                    hi_ok_d = 1'b0;
                end else if (timer_q >= WAKE_TO_DISC[W-1:0]) begin
                    state_d = ST_IDLE;
                end
            end
            ST_DISC: begin
                if (fall) begin
                    hi_ok_d = in_win(width_q, PULSE_MIN, PULSE_MAX);
                    if (!hi_ok_d) begin
                        count_d = 4'h0;
                    end else begin
                        // high then low is one pulse
                        count_d = count_q + 4'h1;
                    end
                end else if (rise) begin
                    if (!in_win(width_q, PULSE_MIN, PULSE_MAX)) begin
                        count_d = 4'h0;
                    end else if (count_q >= SINK_PULSES[3:0]) begin
                        // switch only after the required count
                        state_d = ST_CONNECT;
                    end
                end else if (!lvl_q && width_q > PULSE_MAX[W-1:0]) begin
                    // overlong low clears; in standby it also gives up the attempt
                    count_d = 4'h0;
                    state_d = standby_in ? ST_IDLE : ST_DISC;
                end
                if (!enable_in) begin
                    state_d = ST_IDLE;
                end
            end
            ST_CONNECT: begin
                // pull-down swaps on this same cycle, well inside the delay
                state_d = ST_CONNECTED;
                timer_d = '0;
                term_d  = 1'b0;
            end
            ST_CONNECTED: begin
                // termination once connected, at most one cycle late
                term_d = 1'b1;
                // continuous low past the interval disconnects
                if ((!lvl_q && width_q >= DISCONNECT[W-1:0]) || !enable_in) begin
                    state_d = ST_IDLE;
                    term_d  = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            width_q <= '0;
            timer_q <= '0;
            wake_q  <= 3'h0;
            count_q <= 4'h0;
            hi_ok_q <= 1'b0;
            term_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            width_q <= width_d;
            timer_q <= timer_d;
            wake_q  <= wake_d;
            count_q <= count_d;
            hi_ok_q <= hi_ok_d;
            term_q  <= term_d;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    cwd_pkg::cwd_pulldown_t pd_q;
    cwd_pkg::cwd_pulldown_t pd_d;
    cwd_pkg::cwd_status_t   st_q;
    cwd_pkg::cwd_status_t   st_d;

    // connected flag set with the connected pull-down, on the qualified rise after reaching the count
    always_comb begin
        if (!enable_in) begin
            pd_d = cwd_pkg::CWD_PD_LEAK;
        end else if (state_d == ST_CONNECT || state_d == ST_CONNECTED) begin
            pd_d = cwd_pkg::CWD_PD_CONNECTED;
        end else begin
            pd_d = cwd_pkg::CWD_PD_DISCOVER;
        end
        st_d.armed           = (state_d == ST_ARMED);
        st_d.connected       = (state_d == ST_CONNECT || state_d == ST_CONNECTED);
        st_d.pair_terminated = term_d;
        st_d.pulse_count     = count_d;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pd_q <= cwd_pkg::CWD_PD_LEAK;
            st_q <= '0;
        end else begin
            pd_q <= pd_d;
            st_q <= st_d;
        end
    end

    assign pulldown_out            = pd_q;
    assign media_pair_pos_term_out = st_q.pair_terminated;
    assign media_pair_neg_term_out = st_q.pair_terminated;
    assign status_out              = st_q;

endmodule : cwd_sink

`default_nettype wire

/* pkg/cwd_pkg.sv */
// package for the control wire discovery sink: timing counts and carrier types
package cwd_pkg;

    // ========================================================================
    // clock and timing figures
    // ========================================================================
    localparam int unsigned CLK_MHZ = 100;

    // wake pulse widths, nominal window (us)
    localparam int unsigned WAKE_ONE_MIN_US = 15;
    localparam int unsigned WAKE_ONE_MAX_US = 25;
    localparam int unsigned WAKE_TWO_MIN_US = 45;
    localparam int unsigned WAKE_TWO_MAX_US = 75;
    localparam int unsigned WAKE_TO_DISC_US = 100;

    // discovery pulse accept window (us)
    localparam int unsigned PULSE_MIN_US = 60;
    localparam int unsigned PULSE_MAX_US = 240;

    // connected-state delays (us)
    localparam int unsigned CONNECT_DELAY_US   = 1;
    localparam int unsigned TERM_ENABLE_US     = 100;
    localparam int unsigned DISCONNECT_US      = 150;

    localparam int unsigned SINK_PULSES = 8;

    // cycle counts; each time in us multiplied by the clock in MHz, with no rounding
    localparam int unsigned WAKE_ONE_MIN_CYC  = WAKE_ONE_MIN_US * CLK_MHZ;
    localparam int unsigned WAKE_ONE_MAX_CYC  = WAKE_ONE_MAX_US * CLK_MHZ;
    localparam int unsigned WAKE_TWO_MIN_CYC  = WAKE_TWO_MIN_US * CLK_MHZ;
    localparam int unsigned WAKE_TWO_MAX_CYC  = WAKE_TWO_MAX_US * CLK_MHZ;
    localparam int unsigned WAKE_TO_DISC_CYC  = WAKE_TO_DISC_US * CLK_MHZ;
    localparam int unsigned PULSE_MIN_CYC     = PULSE_MIN_US * CLK_MHZ;
    localparam int unsigned PULSE_MAX_CYC     = PULSE_MAX_US * CLK_MHZ;
    localparam int unsigned CONNECT_DELAY_CYC = CONNECT_DELAY_US * CLK_MHZ;
    localparam int unsigned TERM_ENABLE_CYC   = TERM_ENABLE_US * CLK_MHZ;
    localparam int unsigned DISCONNECT_CYC    = DISCONNECT_US * CLK_MHZ;

    localparam int unsigned WIDTH_BITS = 16;

    // ========================================================================
    // carrier types
    // ========================================================================
    // pull-down selection driven toward the analog pad
    typedef enum logic [1:0] {
        CWD_PD_LEAK,
        CWD_PD_DISCOVER,
        CWD_PD_CONNECTED
    } cwd_pulldown_t;

    // status bundle toward the rest of the device
    typedef struct packed {
        logic       armed;
        logic       connected;
        logic       pair_terminated;
        logic [3:0] pulse_count;
    } cwd_status_t;

endpackage : cwd_pkg

/* test/cwd_sink_chk.sv */
// port-level assertion checker for the discovery sink
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker
module cwd_sink_chk #(
    parameter int unsigned DISCONNECT  = 30,
    parameter int unsigned SINK_PULSES = 8,
    parameter int          TERM_ENABLE = 4
) (
    input wire logic                   clk_in,
    input wire logic                   nrst_in,
    input wire logic                   enable_in,
    input wire logic                   standby_in,
    input wire logic                   control_wire_in,
    input wire cwd_pkg::cwd_pulldown_t pulldown_out,
    input wire logic                   media_pair_pos_term_out,
    input wire logic                   media_pair_neg_term_out,
    input wire cwd_pkg::cwd_status_t   status_out
);
    logic [15:0] low_cnt_q;
    logic [15:0] low_cnt_d;
    // saturates so a parked low wire never wraps back to a short count
    always_comb begin
        low_cnt_d = low_cnt_q;
        if (control_wire_in)
            low_cnt_d = 16'h0000;
        else if (low_cnt_q != 16'hffff)
            low_cnt_d = low_cnt_q + 16'h0001;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            low_cnt_q <= 16'h0000;
        else
            low_cnt_q <= low_cnt_d;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_pd_on;
        $rose(pulldown_out == cwd_pkg::CWD_PD_CONNECTED);
    endsequence
    sequence s_terms;
        media_pair_pos_term_out && media_pair_neg_term_out;
    endsequence
    chk_no_early_conn: assert property (s_pd_on |-> $past(status_out.pulse_count) >= SINK_PULSES)
        else $error("connected pull-down before enough pulses");
    chk_conn_follows: assert property (s_pd_on |-> ##[0:2] status_out.connected)
        else $error("connected flag missing after pull-down switch");
    chk_term_in_time: assert property ($rose(status_out.connected) |-> ##[0:TERM_ENABLE] s_terms)
        else $error("pair termination late");
    chk_term_pair: assert property (media_pair_pos_term_out == media_pair_neg_term_out)
        else $error("pair terminations differ");
    chk_drop_on_low: assert property (low_cnt_q == DISCONNECT + 8 |->
        !status_out.connected && pulldown_out != cwd_pkg::CWD_PD_CONNECTED)
        else $error("no disconnect after long low");
    chk_no_early_drop: assert property ($fell(status_out.connected) |->
        low_cnt_q >= DISCONNECT || !enable_in || !$past(enable_in))
        else $error("disconnect without long low");
    chk_idle_clear: assert property (!enable_in ##1 !enable_in ##1 !enable_in |->
        status_out.pulse_count == 4'h0 && !status_out.connected)
        else $error("count not cleared while idle");
    chk_count_step: assert property ($changed(status_out.pulse_count) |-> status_out.pulse_count == 4'h0
        || status_out.pulse_count - $past(status_out.pulse_count) == 4'h1)
        else $error("pulse count jumped");
endmodule : cwd_sink_chk
bind cwd_sink cwd_sink_chk #(.DISCONNECT(DISCONNECT), .SINK_PULSES(SINK_PULSES),
    .TERM_ENABLE(TERM_ENABLE)) chk (.clk_in(clk_in), .nrst_in(nrst_in), .enable_in(enable_in),
    .standby_in(standby_in), .control_wire_in(control_wire_in), .pulldown_out(pulldown_out),
    .media_pair_pos_term_out(media_pair_pos_term_out),
    .media_pair_neg_term_out(media_pair_neg_term_out), .status_out(status_out));
`default_nettype wire

/* test/cwd_src_model.sv */
// behavioural source driving wake and discovery pulses on the control wire
`timescale 1ns/1ps
`default_nettype none
module cwd_src_model #(
    parameter int MAX_PULSES = 12
) (
    input  wire logic clk_in,
    input  wire logic control_wire_in,
    input  wire cwd_pkg::cwd_pulldown_t pulldown_in,
    output logic      drive_hi_out,
    output logic      hold_low_out,
    output logic      linked_out
);
    initial begin
        drive_hi_out = 1'b0;
        hold_low_out = 1'b0;
        linked_out = 1'b0;
    end
    // called on a falling edge; released leaves the level to the sink's pull-down
    task automatic phase(input logic hi, input int n);
        drive_hi_out = hi;
        repeat (n) @(negedge clk_in);
    endtask : phase
    // two wide-gap pulses, extra low, two narrow pulses
    task automatic wake(input int w1, input int w2);
        phase(1'b1, w1); phase(1'b0, w2); phase(1'b1, w1); phase(1'b0, 2 * w2);
        phase(1'b1, w1); phase(1'b0, w1); phase(1'b1, w1); phase(1'b0, w1);
    endtask : wake
    // rel low keeps the wire held, so a following call continues the same low
    task automatic hold_low(input int n, input logic rel);
        hold_low_out = 1'b1;
        repeat (n) @(negedge clk_in);
        if (rel)
            hold_low_out = 1'b0;
    endtask : hold_low
    // float the wire, then see whether the discovery pull-down is there
    task automatic measure(output logic ok);
        drive_hi_out = 1'b0;
        @(negedge clk_in);
        ok = (pulldown_in == cwd_pkg::CWD_PD_DISCOVER);
    endtask : measure
    // drive, float, stop on a high float or at the maximum
    task automatic discover(input int n, input int hw, input int lw);
        int k;
        k = 0;
        linked_out = 1'b0;
        while (k < n && k < MAX_PULSES && !linked_out) begin
            phase(1'b1, hw);
            drive_hi_out = 1'b0;
            repeat (lw) begin
                @(negedge clk_in);
                if (control_wire_in)
                    linked_out = 1'b1;
            end
            k++;
        end
    endtask : discover
endmodule : cwd_src_model
`default_nettype wire

/* test/control_wire_discovery_test.sv */
// self-checking bench for the discovery sink against a source model
`timescale 1ns/1ps
`default_nettype none
module control_wire_discovery_test;
    logic                   clk_in, nrst_in, enable_in, standby_in;
    logic                   src_hi, src_low, src_linked, term_p, term_n;
    cwd_pkg::cwd_pulldown_t pd;
    cwd_pkg::cwd_status_t   st;
    wire logic              wire_lvl;
    int                     fails, cmp_count;
    logic                   imp_ok;
    // small cycle counts keep the run short; the sink refuses ones that do not fit
    localparam int unsigned T_PMIN  = 6;
    localparam int unsigned T_PMAX  = 24;
    localparam int unsigned T_W1MIN = 4;
    localparam int unsigned T_W1MAX = 8;
    localparam int unsigned T_W2MIN = 12;
    localparam int unsigned T_W2MAX = 20;
    localparam int unsigned T_WTD   = 40;
    localparam int unsigned T_CONN  = 8;
    localparam int unsigned T_TERM  = 4;
    localparam int unsigned T_DISC  = 30;
    localparam int unsigned N_PULSE = 8;
    localparam int          N_SRC   = 12;
    // connected pull-down keeps a floating wire high, otherwise it falls
    assign wire_lvl = src_hi || (!src_low && pd == cwd_pkg::CWD_PD_CONNECTED);
    cwd_sink #(.PULSE_MIN(T_PMIN), .PULSE_MAX(T_PMAX), .WAKE_ONE_MIN(T_W1MIN),
        .WAKE_ONE_MAX(T_W1MAX), .WAKE_TWO_MIN(T_W2MIN), .WAKE_TWO_MAX(T_W2MAX),
        .WAKE_TO_DISC(T_WTD), .CONNECT_DELAY(T_CONN), .TERM_ENABLE(T_TERM),
        .DISCONNECT(T_DISC), .SINK_PULSES(N_PULSE)) dut (.clk_in(clk_in),
        .nrst_in(nrst_in), .enable_in(enable_in), .standby_in(standby_in),
        .control_wire_in(wire_lvl), .pulldown_out(pd), .media_pair_pos_term_out(term_p),
        .media_pair_neg_term_out(term_n), .status_out(st));
    cwd_src_model #(.MAX_PULSES(N_SRC)) src (.clk_in(clk_in), .control_wire_in(wire_lvl),
        .pulldown_in(pd),
        .drive_hi_out(src_hi), .hold_low_out(src_low), .linked_out(src_linked));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic t_reset;
        nrst_in = 1'b0;
        repeat (5) @(negedge clk_in);
        check("pd_rst", pd, cwd_pkg::CWD_PD_LEAK);
        check("st_rst", st, 8'h00);
        nrst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        check("pd_idle", pd, cwd_pkg::CWD_PD_DISCOVER);
    endtask : t_reset
    task automatic t_active;
        standby_in = 1'b0;
        t_reset();
        src.discover(8, 12, 12);
        check("cnt8", st.pulse_count, 8'h08);
        check("no_conn", pd, cwd_pkg::CWD_PD_DISCOVER);
        src.discover(1, 12, 12);
        repeat (2) @(negedge clk_in);
        check("src_link", src_linked, 1'b1);
        check("conn", st.connected, 1'b1);
        check("term", {term_p, term_n}, 8'h03);
        src.hold_low(20, 1'b0);
        check("hold_conn", st.connected, 1'b1);
        src.hold_low(40, 1'b1);
        check("drop", st.connected, 1'b0);
        check("drop_pd", pd == cwd_pkg::CWD_PD_CONNECTED, 1'b0);
    endtask : t_active
    task automatic t_bad;
        t_reset();
        src.discover(3, 12, 12);
        check("cnt3", st.pulse_count, 8'h03);
        src.discover(1, 3, 12);
        check("short_hi", st.pulse_count, 8'h00);
        src.discover(2, 12, 12);
        src.phase(1'b0, 20);
        src.discover(1, 12, 12);
        check("long_lo", st.pulse_count, 8'h01);
        src.discover(1, 30, 12);
        check("long_hi", st.pulse_count, 8'h00);
    endtask : t_bad
    task automatic t_standby;
        standby_in = 1'b1;
        t_reset();
        src.discover(9, 12, 12);
        check("no_wake", st.connected, 1'b0);
        src.phase(1'b0, 50);
        src.wake(12, 16);
        src.discover(N_SRC, 12, 12);
        check("bad_wake", st.connected, 1'b0);
        check("no_link", src_linked, 1'b0);
        src.phase(1'b0, 50);
        // after the maximum, recheck the impedance before retrying
        src.measure(imp_ok);
        check("imp_ok", imp_ok, 1'b1);
        // a fresh wake follows the failed attempt
        src.wake(6, 16);
        check("armed", st.armed, 1'b1);
        src.discover(9, 12, 12);
        repeat (2) @(negedge clk_in);
        check("wake_conn", st.connected, 1'b1);
    endtask : t_standby
    task automatic t_enable;
        enable_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check("off_conn", st.connected, 1'b0);
        check("off_pd", pd, cwd_pkg::CWD_PD_LEAK);
        check("off_cnt", st.pulse_count, 8'h00);
        enable_in = 1'b1;
    endtask : t_enable
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // the whole sequence needs well under 10000 cycles
    initial begin
        #200_000;
        fails++;
        close_out();
    end
    initial begin
        nrst_in = 1'b0;
        enable_in = 1'b1;
        standby_in = 1'b0;
        fails = 0;
        cmp_count = 0;
        @(negedge clk_in);
        t_active();
        t_bad();
        t_standby();
        t_enable();
        close_out();
    end
endmodule : control_wire_discovery_test
`default_nettype wire
